// [cfg_consts.svh]
// constants for the converter configuration reset and format link
// Summary of operation
// - format bit picks two's complement or offset binary
// - format applies only with digital bypass enabled
// - host pulses reset pin high after power-up
// - release loads fuse defaults, then long calibration
// - reference select driven, clock running before reset
// - writing one to reset bit restores defaults
// - software reset bit clears itself
// - reset pin held low during serial reset
// - host waits calibration time before programming
`ifndef CFG_CONSTS_SVH
`define CFG_CONSTS_SVH

`define CALIB_CYCLES 200000
`define FUSE_CYCLES 4
`define HW_PULSE_CYCLES 16
`define SPI_HALF_CYCLES 4
`define SAMPLE_W 14

`define FRAME_BITS 5'd24
`define FRAME_CMD_DONE 5'd15
`define FRAME_LAST 5'd23
`define FRAME_RD_FIRST 5'd16
`define CMD_READ 8'h80
`define CMD_WRITE 8'h00

`define ADDR_SWRST 8'h00
`define ADDR_BYPASS 8'h24
`define ADDR_FORMAT 8'h8F
`define SWRST_BIT 0
`define BYPASS_EN_BIT 2
`define FORMAT_BIT 1
`define SWRST_RESET 1'b0
`define BYPASS_RESET 8'h00
`define FORMAT_RESET 8'h00
`define SWRST_DATA 8'h01

`define HOST_CTRL 8'h00
`define HOST_CMD 8'h04
`define HOST_STATUS 8'h08
`define CTRL_HW_RESET_BIT 0
`define CTRL_SW_RESET_BIT 1
`define CTRL_REF_BIT 2
`define CMD_READ_BIT 16
`define AXI_OKAY 2'b00
`define AXI_SLVERR 2'b10

`endif

// [cfg_pkg.sv]
// types shared by both ends of the configuration link
package cfg_pkg;
  typedef enum logic [1:0] {
    DEV_HOLD = 2'b00,
    DEV_FUSE = 2'b01,
    DEV_CALIB = 2'b10,
    DEV_READY = 2'b11
  } dev_state_t;

  typedef enum logic [1:0] {
    HOST_IDLE = 2'b00,
    HOST_RST = 2'b01,
    HOST_WAIT = 2'b10,
    HOST_SPI = 2'b11
  } host_state_t;
endpackage

// [cfg_link_if.sv]
// pins between the host controller and the converter configuration logic
`timescale 1ns/1ps
`default_nettype none
interface cfg_link_if;
  logic hw_reset;
  logic reference_select_pin;
  logic sen_n;
  logic sclk;
  logic sdi;
  logic sdo;

  modport device (
    input hw_reset,
    input reference_select_pin,
    input sen_n,
    input sclk,
    input sdi,
    output sdo
  );

  modport host (
    output hw_reset,
    output reference_select_pin,
    output sen_n,
    output sclk,
    output sdi,
    input sdo
  );
endinterface
`default_nettype wire

// [cfg_device.sv]
// converter end: reset pin, fuse load, calibration, serial registers, format
`timescale 1ns/1ps
`default_nettype none
`include "cfg_consts.svh"
module cfg_device import cfg_pkg::*; #(
  parameter int unsigned CALIB_CYCLES = `CALIB_CYCLES,
  parameter int unsigned FUSE_CYCLES = `FUSE_CYCLES,
  parameter int unsigned SAMPLE_W = `SAMPLE_W
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  cfg_link_if.device link,
  input wire logic [SAMPLE_W-1:0] sample_i,
  output logic [SAMPLE_W-1:0] sample_o,
  output logic ready_o,
  output logic offset_binary_o,
  output logic reference_internal_o
);

  if (CALIB_CYCLES < 1 || FUSE_CYCLES < 1 || SAMPLE_W < 2) begin : g_bad_param
    $error("cfg_device: counts must be at least one and samples two bits");
  end

  dev_state_t state_q, state_d;
  logic [31:0] cnt_q, cnt_d;
  logic swrst_q, swrst_d;
  logic [7:0] bypass_q, bypass_d;
  logic [7:0] format_q, format_d;
  logic ref_q, ref_d;

  logic sclk_q, sclk_d;
  logic [4:0] bit_cnt_q, bit_cnt_d;
  logic [23:0] shift_q, shift_d;
  logic [7:0] addr_q, addr_d;
  logic read_q, read_d;
  logic [7:0] rd_shift_q, rd_shift_d;

  logic [SAMPLE_W-1:0] sample_q, sample_d;
  logic offset_q, offset_d;

  logic sclk_rise;
  logic sclk_fall;
  logic [23:0] shift_next;
  logic wr_strobe;

  function automatic logic [7:0] read_reg(input logic [7:0] addr,
                                          input logic swrst,
                                          input logic [7:0] bypass,
                                          input logic [7:0] format);
    logic [7:0] val;
    val = 8'h00;
    if (addr == `ADDR_SWRST) begin
      val = {7'h00, swrst};
    end else if (addr == `ADDR_BYPASS) begin
      val = bypass;
    end else if (addr == `ADDR_FORMAT) begin
      val = format;
    end
    return val;
  endfunction

  assign sclk_rise = link.sclk & ~sclk_q & ~link.sen_n;
  assign sclk_fall = ~link.sclk & sclk_q & ~link.sen_n;
  assign shift_next = {shift_q[22:0], link.sdi};
  // a write only lands once the whole data byte is in
  assign wr_strobe = sclk_rise && bit_cnt_q == `FRAME_LAST && !read_q;

  // serial frame: command byte, address byte, data byte, msb first
  always_comb begin
    sclk_d = link.sclk;
    bit_cnt_d = bit_cnt_q;
    shift_d = shift_q;
    addr_d = addr_q;
    read_d = read_q;
    rd_shift_d = rd_shift_q;
    if (link.sen_n) begin
      bit_cnt_d = 5'd0;
      read_d = 1'b0;
    end else if (sclk_rise) begin
      shift_d = shift_next;
      bit_cnt_d = bit_cnt_q + 5'd1;
      if (bit_cnt_q == `FRAME_CMD_DONE) begin
        addr_d = shift_next[7:0];
        read_d = (shift_next[15:8] & `CMD_READ) != 8'h00;
        rd_shift_d = read_reg(shift_next[7:0], swrst_q, bypass_q, format_q);
      end
    end else if (sclk_fall && bit_cnt_q > `FRAME_RD_FIRST) begin
      rd_shift_d = {rd_shift_q[6:0], 1'b0};
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sclk_q <= 1'b0;
      bit_cnt_q <= 5'd0;
      shift_q <= 24'h000000;
      addr_q <= 8'h00;
      read_q <= 1'b0;
      rd_shift_q <= 8'h00;
    end else begin
      sclk_q <= sclk_d;
      bit_cnt_q <= bit_cnt_d;
      shift_q <= shift_d;
      addr_q <= addr_d;
      read_q <= read_d;
      rd_shift_q <= rd_shift_d;
    end
  end

  assign link.sdo = rd_shift_q[7];

  // reset sequencing and the configuration registers
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    swrst_d = swrst_q;
    bypass_d = bypass_q;
    format_d = format_q;
    ref_d = ref_q;
    case (state_q)
      DEV_HOLD: begin
        // pin high keeps the reset, bypass and format registers at default
        swrst_d = `SWRST_RESET;
        bypass_d = `BYPASS_RESET;
        format_d = `FORMAT_RESET;
        cnt_d = 32'd0;
        if (!link.hw_reset) begin
          // strap caught on the falling edge of the reset pin
          ref_d = link.reference_select_pin;
          state_d = DEV_FUSE;
        end
      end
      DEV_FUSE: begin
        // fuse image equals the reset values in this model
        bypass_d = `BYPASS_RESET;
        format_d = `FORMAT_RESET;
        swrst_d = `SWRST_RESET;
        if (cnt_q == 32'(FUSE_CYCLES - 1)) begin
          cnt_d = 32'd0;
          state_d = DEV_CALIB;
        end else begin
          cnt_d = cnt_q + 32'd1;
        end
      end
      DEV_CALIB: begin
        if (cnt_q == 32'(CALIB_CYCLES - 1)) begin
          cnt_d = 32'd0;
          state_d = DEV_READY;
        end else begin
          cnt_d = cnt_q + 32'd1;
        end
      end
      DEV_READY: begin
        if (swrst_q) begin
          // one cycle of visible set bit, then self clear
          swrst_d = 1'b0;
          bypass_d = `BYPASS_RESET;
          format_d = `FORMAT_RESET;
          cnt_d = 32'd0;
          state_d = DEV_FUSE;
        end else if (wr_strobe) begin
          if (addr_q == `ADDR_SWRST) begin
            swrst_d = shift_next[`SWRST_BIT];
          end else if (addr_q == `ADDR_BYPASS) begin
            bypass_d = shift_next[7:0];
          end else if (addr_q == `ADDR_FORMAT) begin
            format_d = shift_next[7:0];
          end
        end
      end
      default: begin
        state_d = DEV_HOLD;
      end
    endcase
    // the pin overrides any sequence in progress
    if (link.hw_reset) begin
      state_d = DEV_HOLD;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= DEV_HOLD;
      cnt_q <= 32'd0;
      swrst_q <= `SWRST_RESET;
      bypass_q <= `BYPASS_RESET;
      format_q <= `FORMAT_RESET;
      ref_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      swrst_q <= swrst_d;
      bypass_q <= bypass_d;
      format_q <= format_d;
      ref_q <= ref_d;
    end
  end

  // sample coding: flipping the sign bit turns two's complement into offset
  always_comb begin
    offset_d = bypass_q[`BYPASS_EN_BIT] & format_q[`FORMAT_BIT];
    sample_d = sample_i;
    if (offset_q) begin
      sample_d[SAMPLE_W-1] = ~sample_i[SAMPLE_W-1];
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      offset_q <= 1'b0;
      sample_q <= '0;
    end else begin
      offset_q <= offset_d;
      sample_q <= sample_d;
    end
  end

  assign sample_o = sample_q;
  assign offset_binary_o = offset_q;
  assign ready_o = state_q == DEV_READY;
  assign reference_internal_o = ref_q;

endmodule
`default_nettype wire

// [cfg_host.sv]
// host end: axi4-lite registers driving the reset pin and serial port
`timescale 1ns/1ps
`default_nettype none
`include "cfg_consts.svh"
module cfg_host import cfg_pkg::*; #(
  parameter int unsigned WAIT_CYCLES = `CALIB_CYCLES,
  parameter int unsigned HW_PULSE_CYCLES = `HW_PULSE_CYCLES,
  parameter int unsigned SPI_HALF_CYCLES = `SPI_HALF_CYCLES
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  cfg_link_if.host link,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  if (WAIT_CYCLES < 1 || HW_PULSE_CYCLES < 1 || SPI_HALF_CYCLES < 2) begin : g_bad_param
    $error("cfg_host: counts too small, serial half period needs two cycles");
  end

  host_state_t state_q, state_d;
  logic [31:0] cnt_q, cnt_d;
  logic aw_q, aw_d, w_q, w_d, bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [7:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic ref_q, ref_d, refused_q, refused_d, sw_wait_q, sw_wait_d;
  logic sen_n_q, sen_n_d, sclk_q, sclk_d;
  logic [4:0] bit_q, bit_d;
  logic [23:0] shift_q, shift_d;
  logic [7:0] rx_q, rx_d;

  logic do_write;
  logic [31:0] wr_val;
  logic idle;

  function automatic logic [31:0] lanes(input logic [31:0] d, input logic [3:0] s);
    logic [31:0] m;
    m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    return d & m;
  endfunction

  assign do_write = aw_q && w_q && !bvalid_q;
  assign wr_val = lanes(wdata_q, wstrb_q);
  assign idle = state_q == HOST_IDLE;

  always_comb begin
    aw_d = aw_q;
    w_d = w_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    if (do_write) begin
      aw_d = 1'b0;
      w_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = (awaddr_q == `HOST_CTRL || awaddr_q == `HOST_CMD) ? `AXI_OKAY : `AXI_SLVERR;
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rresp_d = `AXI_OKAY;
      rdata_d = 32'h00000000;
      if (s_axi_araddr == `HOST_CTRL) begin
        rdata_d[`CTRL_REF_BIT] = ref_q;
      end else if (s_axi_araddr == `HOST_STATUS) begin
        rdata_d = {16'h0000, rx_q, 4'h0, ref_q, refused_q, state_q == HOST_WAIT, !idle};
      end else if (s_axi_araddr != `HOST_CMD) begin
        rresp_d = `AXI_SLVERR;
      end
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
  end

  // sequencer and serial master
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    ref_d = ref_q;
    refused_d = refused_q;
    sw_wait_d = sw_wait_q;
    sen_n_d = sen_n_q;
    sclk_d = sclk_q;
    bit_d = bit_q;
    shift_d = shift_q;
    rx_d = rx_q;
    if (do_write && awaddr_q == `HOST_CTRL && wstrb_q[0]) begin
      ref_d = wr_val[`CTRL_REF_BIT];
    end
    case (state_q)
      HOST_IDLE: begin
        cnt_d = 32'd0;
        if (do_write && awaddr_q == `HOST_CTRL && wr_val[`CTRL_HW_RESET_BIT]) begin
          state_d = HOST_RST;
          refused_d = 1'b0;
        end else if (do_write && awaddr_q == `HOST_CTRL && wr_val[`CTRL_SW_RESET_BIT]) begin
          shift_d = {`CMD_WRITE, `ADDR_SWRST, `SWRST_DATA};
          sw_wait_d = 1'b1;
          sen_n_d = 1'b0;
          bit_d = 5'd0;
          state_d = HOST_SPI;
          refused_d = 1'b0;
        end else if (do_write && awaddr_q == `HOST_CMD) begin
          shift_d = {wr_val[`CMD_READ_BIT] ? `CMD_READ : `CMD_WRITE, wr_val[15:0]};
          sw_wait_d = 1'b0;
          sen_n_d = 1'b0;
          bit_d = 5'd0;
          state_d = HOST_SPI;
          refused_d = 1'b0;
        end
      end
      HOST_RST: begin
        if (cnt_q == 32'(HW_PULSE_CYCLES - 1)) begin
          cnt_d = 32'd0;
          state_d = HOST_WAIT;
        end else begin
          cnt_d = cnt_q + 32'd1;
        end
      end
      HOST_WAIT: begin
        if (cnt_q == 32'(WAIT_CYCLES - 1)) begin
          cnt_d = 32'd0;
          state_d = HOST_IDLE;
        end else begin
          cnt_d = cnt_q + 32'd1;
        end
      end
      HOST_SPI: begin
        if (cnt_q == 32'(SPI_HALF_CYCLES - 1)) begin
          cnt_d = 32'd0;
          sclk_d = !sclk_q;
          if (sclk_q) begin
            if (bit_q >= `FRAME_RD_FIRST) begin
              rx_d = {rx_q[6:0], link.sdo};
            end
            shift_d = {shift_q[22:0], 1'b0};
            bit_d = bit_q + 5'd1;
            if (bit_q == `FRAME_LAST) begin
              sen_n_d = 1'b1;
              state_d = sw_wait_q ? HOST_WAIT : HOST_IDLE;
            end
          end
        end else begin
          cnt_d = cnt_q + 32'd1;
        end
      end
      default: begin
        state_d = HOST_IDLE;
      end
    endcase
    // commands and reset requests arriving while busy are dropped and flagged; the reference bit still updates
    if (do_write && !idle && awaddr_q != `HOST_STATUS) begin
      if (awaddr_q == `HOST_CMD || wr_val[`CTRL_HW_RESET_BIT] || wr_val[`CTRL_SW_RESET_BIT]) begin
        refused_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= HOST_RST;
      cnt_q <= 32'd0;
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `AXI_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= `AXI_OKAY;
      ref_q <= 1'b0;
      refused_q <= 1'b0;
      sw_wait_q <= 1'b0;
      sen_n_q <= 1'b1;
      sclk_q <= 1'b0;
      bit_q <= 5'd0;
      shift_q <= 24'h000000;
      rx_q <= 8'h00;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      aw_q <= aw_d;
      w_q <= w_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      ref_q <= ref_d;
      refused_q <= refused_d;
      sw_wait_q <= sw_wait_d;
      sen_n_q <= sen_n_d;
      sclk_q <= sclk_d;
      bit_q <= bit_d;
      shift_q <= shift_d;
      rx_q <= rx_d;
    end
  end

  assign s_axi_awready = !aw_q && !bvalid_q;
  assign s_axi_wready = !w_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  // pin is low in every state but the pulse, so serial reset sees it low
  assign link.hw_reset = state_q == HOST_RST;
  assign link.reference_select_pin = ref_q;
  assign link.sen_n = sen_n_q;
  assign link.sclk = sclk_q;
  assign link.sdi = shift_q[23];

endmodule
`default_nettype wire

// [cfg_link_sva.sv]
// assertions on the configuration link pins and the converter outputs
`timescale 1ns/1ps
`default_nettype none
module cfg_link_sva #(
  parameter int unsigned CALIB_CYCLES = 50,
  parameter int unsigned FUSE_CYCLES = 4,
  parameter int unsigned HW_PULSE_CYCLES = 4,
  parameter int unsigned SAMPLE_W = 14
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic hw_reset,
  input wire logic reference_select_pin,
  input wire logic sen_n,
  input wire logic sclk,
  input wire logic ready_o,
  input wire logic offset_binary_o,
  input wire logic reference_internal_o,
  input wire logic [SAMPLE_W-1:0] sample_i,
  input wire logic [SAMPLE_W-1:0] sample_o
);
  localparam int unsigned SETTLE = FUSE_CYCLES + CALIB_CYCLES;
  logic [31:0] hi_cnt_q, hi_cnt_d, wait_cnt_q, wait_cnt_d, rise_cnt_q, rise_cnt_d;
  logic sclk_q;

  // settle count restarts whenever the pin is high or the device is up
  always_comb begin
    hi_cnt_d = hw_reset ? hi_cnt_q + 32'd1 : 32'd0;
    wait_cnt_d = (hw_reset || ready_o) ? 32'd0 : wait_cnt_q + 32'd1;
    rise_cnt_d = sen_n ? 32'd0 : rise_cnt_q + 32'(sclk && !sclk_q);
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hi_cnt_q <= 32'd0;
      wait_cnt_q <= 32'd0;
      rise_cnt_q <= 32'd0;
      sclk_q <= 1'b0;
    end else begin
      hi_cnt_q <= hi_cnt_d;
      wait_cnt_q <= wait_cnt_d;
      rise_cnt_q <= rise_cnt_d;
      sclk_q <= sclk;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  // offset flag trails the registers by a cycle, so three pin cycles are needed
  sequence s_hold3;
    hw_reset ##1 hw_reset ##1 hw_reset;
  endsequence
  sequence s_frame_open;
    $fell(sen_n) ##0 !sclk;
  endsequence

  chk_pulse_width: assert property ($fell(hw_reset) |-> hi_cnt_q >= HW_PULSE_CYCLES - 1)
    else $error("reset pin pulse too short");
  chk_ready_early: assert property ($rose(ready_o) |-> wait_cnt_q >= SETTLE - 1)
    else $error("ready before fuse load and calibration");
  chk_ready_late: assert property (wait_cnt_q <= SETTLE + 4)
    else $error("calibration overran");
  chk_hold_idle: assert property (hw_reset |=> !ready_o)
    else $error("ready while reset pin high");
  chk_hold_defaults: assert property (s_hold3 |=> !offset_binary_o)
    else $error("format not at default in hold");
  chk_ref_capture: assert property ($fell(hw_reset) |-> ##2 (reference_internal_o == reference_select_pin))
    else $error("reference strap not captured");
  chk_sample_code: assert property (sample_o == ($past(sample_i) ^ {$past(offset_binary_o), {(SAMPLE_W-1){1'b0}}}))
    else $error("sample coding wrong");
  chk_frame_bits: assert property ($rose(sen_n) |-> rise_cnt_q == 32'd24)
    else $error("frame not 24 clocks");
  chk_no_early_frame: assert property (s_frame_open |-> ready_o)
    else $error("frame during calibration");
  chk_pin_low_serial: assert property (!sen_n |-> !hw_reset)
    else $error("reset pin high in frame");
endmodule
`default_nettype wire

// [testbench.sv]
// self-checking bench: host and converter ends joined over the link
`timescale 1ns/1ps
`default_nettype none
`include "cfg_consts.svh"
module testbench;
  logic clk_i, reset_n_i, ready_o, offset_binary_o, reference_internal_o;
  logic [13:0] sample_i, sample_o;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int n_errors = 0, n_compared = 0, cycles = 0;

  // shortened settle so the run stays small; host wait must cover fuse plus calibration
  localparam int unsigned CALIB_SHORT = 50;

  cfg_link_if link();
  cfg_device #(.CALIB_CYCLES(CALIB_SHORT)) u_cfg_device (.clk_i, .reset_n_i,
    .link(link), .sample_i, .sample_o, .ready_o, .offset_binary_o, .reference_internal_o);
  cfg_host #(.WAIT_CYCLES(60), .HW_PULSE_CYCLES(4), .SPI_HALF_CYCLES(2)) u_cfg_host (.clk_i,
    .reset_n_i, .link(link), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  // fuse length, pulse width and sample width match the checker's defaults
  cfg_link_sva #(.CALIB_CYCLES(CALIB_SHORT))
    u_cfg_link_sva (.clk_i, .reset_n_i, .hw_reset(link.hw_reset),
    .reference_select_pin(link.reference_select_pin), .sen_n(link.sen_n), .sclk(link.sclk),
    .ready_o, .offset_binary_o, .reference_internal_o, .sample_i, .sample_o);

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic end_sim;
    if (n_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // whole run needs a few thousand cycles; this only cuts a hang
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      end_sim;
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bready && s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
      end
    end while (s_axi_awvalid || s_axi_wvalid || s_axi_bready);
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rready && s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
      end
    end while (s_axi_arvalid || s_axi_rready);
  endtask

  task automatic wait_idle(output logic [31:0] s);
    logic [1:0] r;
    do axi_rd(`HOST_STATUS, s, r); while (s[1:0] !== 2'b00);
  endtask

  // one serial frame through the command register; v is the byte read back
  task automatic spi(input logic [7:0] a, input logic [7:0] d, input logic rd,
                     output logic [7:0] v);
    logic [1:0] r;
    logic [31:0] s;
    axi_wr(`HOST_CMD, {15'h0, rd, a, d}, r);
    check(32'(r), 32'(`AXI_OKAY));
    wait_idle(s);
    v = s[15:8];
  endtask

  task automatic t_power_up;
    logic [31:0] s;
    logic [1:0] r;
    check(32'(ready_o), 32'h0);
    axi_rd(`HOST_STATUS, s, r);
    check(32'(s[0]), 32'h1);
    wait_idle(s);
    check(32'(ready_o), 32'h1);
    check(32'(reference_internal_o), 32'h0);
  endtask

  task automatic t_refused;
    logic [31:0] s;
    logic [1:0] r;
    logic [7:0] v;
    axi_wr(`HOST_CTRL, 32'h5, r);
    axi_wr(`HOST_CMD, {16'h0, `ADDR_FORMAT, 8'h02}, r);
    axi_rd(`HOST_STATUS, s, r);
    check(32'(s[2]), 32'h1);
    check(32'(ready_o), 32'h0);
    wait_idle(s);
    check(32'(reference_internal_o), 32'h1);
    spi(`ADDR_FORMAT, 8'h00, 1'b1, v);
    check(32'(v), 32'h0);
  endtask

  task automatic t_format;
    logic [7:0] v;
    logic en, fm;
    for (int i = 0; i < 4; i++) begin
      en = i[1];
      fm = i[0];
      spi(`ADDR_BYPASS, {5'h0, en, 2'h0}, 1'b0, v);
      spi(`ADDR_FORMAT, {6'h0, fm, 1'b0}, 1'b0, v);
      spi(`ADDR_FORMAT, 8'h00, 1'b1, v);
      check(32'(v), 32'({fm, 1'b0}));
      check(32'(offset_binary_o), 32'(en & fm));
      @(posedge clk_i) sample_i <= 14'h0123;
      @(posedge clk_i);
      @(posedge clk_i);
      #1;
      check(32'(sample_o), 32'(14'h0123 ^ {en & fm, 13'h0}));
      @(posedge clk_i) sample_i <= 14'h0;
    end
  endtask

  task automatic t_swreset;
    logic [31:0] s;
    logic [1:0] r;
    logic [7:0] v;
    axi_wr(`HOST_CTRL, 32'h6, r);
    axi_rd(`HOST_STATUS, s, r);
    check(32'(s[0]), 32'h1);
    wait_idle(s);
    check(32'(offset_binary_o), 32'h0);
    spi(`ADDR_SWRST, 8'h00, 1'b1, v);
    check(32'(v), 32'h0);
    spi(`ADDR_BYPASS, 8'h00, 1'b1, v);
    check(32'(v), 32'(`BYPASS_RESET));
    spi(`ADDR_FORMAT, 8'h00, 1'b1, v);
    check(32'(v), 32'(`FORMAT_RESET));
    // pin reset taken while offset coding is live
    spi(`ADDR_BYPASS, 8'h04, 1'b0, v);
    spi(`ADDR_FORMAT, 8'h02, 1'b0, v);
    check(32'(offset_binary_o), 32'h1);
    axi_wr(`HOST_CTRL, 32'h1, r);
    wait_idle(s);
    check(32'(offset_binary_o), 32'h0);
    check(32'(reference_internal_o), 32'h0);
    spi(`ADDR_FORMAT, 8'h00, 1'b1, v);
    check(32'(v), 32'(`FORMAT_RESET));
  endtask

  task automatic t_unmapped;
    logic [31:0] d;
    logic [1:0] r;
    axi_wr(8'h0C, 32'h1, r);
    check(32'(r), 32'(`AXI_SLVERR));
    axi_rd(8'h0C, d, r);
    check(32'(r), 32'(`AXI_SLVERR));
    check(d, 32'h0);
    axi_rd(`HOST_CMD, d, r);
    check(d, 32'h0);
  endtask

  initial begin
    reset_n_i = 1'b0;
    sample_i = 14'h0;
    s_axi_awaddr = 8'h0;
    s_axi_araddr = 8'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    t_power_up;
    t_refused;
    t_format;
    t_swreset;
    t_unmapped;
    end_sim;
  end
endmodule
`default_nettype wire
